// >>> hdl/sfe_pkg.sv
// Operation
// - block erase decodes seven page bits, 0-127
// - sector erase clears exactly one sector
// - opcode 7ch selects sector erase
// - any page in sector selects whole sector
// - sector decode: 0a, 0b, top three bits
// - sector erase starts on chip select rise
// - sector erase self-timed, busy throughout
// - only exact c7 94 80 9a erases chip
// - chip erase ignores bytes after sequence
// - chip erase starts on chip select rise
// - chip erase self-timed, busy throughout
// - chip erase skips protected or locked sectors
// - write protect deferred until erase completes
// - opcode 50h block erase, self-timed, busy
// - erased bits read as logic one
package sfe_pkg;
    // clock rate in mhz, 20 ns period
    localparam int unsigned CLK_MHZ = 50;
    // longest erase times in microseconds, plain defaults
    localparam int unsigned BLOCK_ERASE_TIME_US = 25000;
    localparam int unsigned SECTOR_ERASE_TIME_US = 700000;
    localparam int unsigned CHIP_ERASE_TIME_US = 4000000;
    // longest times scaled to whole cycles, microseconds times CLK_MHZ
    localparam int unsigned BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
    localparam int unsigned SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
    localparam int unsigned CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 32;
    // command bytes
    localparam logic [7:0] OPC_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'h7c;
    localparam logic [7:0] CHIP_SEQ_0 = 8'hc7;
    localparam logic [7:0] CHIP_SEQ_1 = 8'h94;
    localparam logic [7:0] CHIP_SEQ_2 = 8'h80;
    localparam logic [7:0] CHIP_SEQ_3 = 8'h9a;
    localparam logic [2:0] CMD_BYTES = 3'h4;
    // page field position in the 24 address bits
    localparam int STD_PAGE_LSB = 9;
    localparam int BIN_PAGE_LSB = 8;
    localparam int PAGE_W = 10;
    localparam int SECTOR_COUNT = 9;
    localparam int SECTOR_IDX_W = 4;
    // page ranges of the array
    localparam logic [9:0] FIRST_PAGE = 10'h000;
    localparam logic [9:0] LAST_PAGE = 10'h3ff;
    localparam logic [9:0] SECTOR_0A_LAST = 10'h007;
    localparam logic [9:0] SECTOR_0B_FIRST = 10'h008;
    localparam logic [9:0] SECTOR_0B_LAST = 10'h07f;
    localparam logic [6:0] SECTOR_PAGE_LAST = 7'h7f;
    localparam logic [2:0] BLOCK_PAGE_LAST = 3'h7;
    // value left in every erased byte
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // one received serial byte
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sfe_byte_type;

    // page strobe toward the array
    typedef struct packed {
        logic we;
        logic [PAGE_W-1:0] page;
        logic [7:0] fill;
    } sfe_erase_port_type;

    // one erase job: page span and duration
    typedef struct packed {
        logic [PAGE_W-1:0] first_page;
        logic [PAGE_W-1:0] last_page;
        logic [TIMER_W-1:0] cycles;
    } sfe_job_type;

    // sector index: 0a=0, 0b=1, sector n = n+1
    function automatic logic [SECTOR_IDX_W-1:0] sector_of(input logic [PAGE_W-1:0] page);
        if (page[9:7] == 3'h0) begin
            sector_of = (page[6:3] == 4'h0) ? 4'h0 : 4'h1;
        end else begin
            sector_of = {1'b0, page[9:7]} + 4'h1;
        end
    endfunction : sector_of
endpackage : sfe_pkg

// >>> hdl/sfe_spi_rx.sv
`timescale 1ns/1ns
// serial byte receiver, mode 0 and 3, runs on oversampled pins
module sfe_spi_rx (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    output sfe_pkg::sfe_byte_type byte_out,
    output logic cs_fall_out,
    output logic cs_rise_out
);
    import sfe_pkg::*;

    logic sck_d; // previous clock sample for edge finding
    logic cs_n_d; // previous select sample
    logic [2:0] bit_cnt; // bits of the current byte
    logic [6:0] shift; // bits gathered so far
    wire sck_rise = sck_in & ~sck_d;
    wire cs_active = ~cs_n_in & ~cs_n_d;

    // edge history; select starts high so no false fall at reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else if (clk_en_in) begin
            sck_d <= sck_in;
            cs_n_d <= cs_n_in;
        end
    end

    // select edges as one-cycle pulses
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_fall_out <= 1'b0;
            cs_rise_out <= 1'b0;
        end else if (clk_en_in) begin
            cs_fall_out <= ~cs_n_in & cs_n_d;
            cs_rise_out <= cs_n_in & ~cs_n_d;
        end
    end

    // shift on rising serial clock; a partial byte is dropped at select rise
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt <= 3'h0;
            shift <= 7'h00;
            byte_out <= '0;
        end else if (clk_en_in) begin
            byte_out.valid <= 1'b0;
            if (!cs_active) begin
                bit_cnt <= 3'h0; // idle select restarts byte framing
            end else if (sck_rise) begin
                bit_cnt <= bit_cnt + 3'h1;
                shift <= {shift[5:0], si_in};
                if (bit_cnt == 3'h7) begin
                    byte_out.valid <= 1'b1;
                    byte_out.data <= {shift, si_in};
                end
            end
        end
    end
endmodule : sfe_spi_rx

// >>> hdl/sfe_erase_ctrl.sv
`timescale 1ns/1ns
// erase command decoder and self-timed erase engine
module sfe_erase_ctrl #(
    parameter int unsigned BLOCK_CYCLES = sfe_pkg::BLOCK_ERASE_CYCLES,
    parameter int unsigned SECTOR_CYCLES = sfe_pkg::SECTOR_ERASE_CYCLES,
    parameter int unsigned CHIP_CYCLES = sfe_pkg::CHIP_ERASE_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    input wire logic binary_page_in,
    input wire logic sw_protect_in,
    input wire logic [sfe_pkg::SECTOR_COUNT-1:0] protect_sel_in,
    input wire logic [sfe_pkg::SECTOR_COUNT-1:0] lockdown_in,
    output logic busy_out,
    output logic protect_active_out,
    output sfe_pkg::sfe_erase_port_type erase_out
);
    import sfe_pkg::*;

    // engine states
    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_SWEEP = 3'b010,
        ENG_WAIT = 3'b100
    } sfe_eng_type;

    logic rst_meta; // reset release stage one
    logic rst_sync; // reset release stage two, used everywhere
    logic cs_n_meta, cs_n_sync; // select synchroniser
    logic sck_meta, sck_sync; // serial clock synchroniser
    logic si_meta, si_sync; // serial data synchroniser
    logic wp_n_meta, wp_n_sync; // write protect synchroniser

    sfe_byte_type rx_byte; // byte from the receiver
    logic cs_fall; // select went low
    logic cs_rise; // select went high
    logic [7:0] cmd_bytes [0:3]; // opcode and three address bytes
    logic [2:0] byte_cnt; // saturates at four

    sfe_eng_type state, next_state;
    logic [PAGE_W-1:0] cur_page, next_cur_page;
    logic [PAGE_W-1:0] last_page, next_last_page;
    logic [TIMER_W-1:0] timer, next_timer;
    logic [TIMER_W-1:0] target, next_target;
    logic wp_latched; // write protect as seen by the array
    sfe_erase_port_type next_erase;

    // reset release through two flops
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // pin synchronisers; idle levels keep select and protect high
    always_ff @(posedge ref_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            {cs_n_meta, cs_n_sync} <= 2'b11;
            {sck_meta, sck_sync} <= 2'b00;
            {si_meta, si_sync} <= 2'b00;
            {wp_n_meta, wp_n_sync} <= 2'b11;
        end else if (clk_en_in) begin
            {cs_n_meta, cs_n_sync} <= {cs_n_in, cs_n_meta};
            {sck_meta, sck_sync} <= {sck_in, sck_meta};
            {si_meta, si_sync} <= {si_in, si_meta};
            {wp_n_meta, wp_n_sync} <= {wp_n_in, wp_n_meta};
        end
    end

    sfe_spi_rx u_rx (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_sync),
        .clk_en_in(clk_en_in),
        .cs_n_in(cs_n_sync),
        .sck_in(sck_sync),
        .si_in(si_sync),
        .byte_out(rx_byte),
        .cs_fall_out(cs_fall),
        .cs_rise_out(cs_rise)
    );

    // capture first four bytes of each frame; later bytes are dropped
    always_ff @(posedge ref_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            byte_cnt <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                cmd_bytes[i] <= 8'h00;
            end
        end else if (clk_en_in) begin
            if (cs_fall) begin
                byte_cnt <= 3'h0;
            end else if (rx_byte.valid && byte_cnt < CMD_BYTES) begin
                cmd_bytes[byte_cnt[1:0]] <= rx_byte.data;
                byte_cnt <= byte_cnt + 3'h1;
            end
        end
    end

    // command decode, complete frames only
    wire frame_full = (byte_cnt == CMD_BYTES);
    wire is_block = frame_full && cmd_bytes[0] == OPC_BLOCK_ERASE;
    wire is_sector = frame_full && cmd_bytes[0] == OPC_SECTOR_ERASE;
    wire is_chip = frame_full && cmd_bytes[0] == CHIP_SEQ_0 && cmd_bytes[1] == CHIP_SEQ_1
        && cmd_bytes[2] == CHIP_SEQ_2 && cmd_bytes[3] == CHIP_SEQ_3;
    wire [23:0] addr_bits = {cmd_bytes[1], cmd_bytes[2], cmd_bytes[3]};
    // page field sits one bit lower in 256-byte mode
    wire [PAGE_W-1:0] page_addr_bits = addr_bits[STD_PAGE_LSB +: PAGE_W];
    wire [PAGE_W-1:0] binary_mode_addr_bits = addr_bits[BIN_PAGE_LSB +: PAGE_W];
    wire [PAGE_W-1:0] cmd_page = binary_page_in ? binary_mode_addr_bits : page_addr_bits;

    // block span: upper seven bits pick one of 128 blocks
    wire [PAGE_W-1:0] blk_first = {cmd_page[9:3], 3'h0};
    wire [PAGE_W-1:0] blk_last = {cmd_page[9:3], BLOCK_PAGE_LAST};

    // sector span from any page inside it, one sector only
    wire in_sector0 = (cmd_page[9:7] == 3'h0);
    wire in_0a = in_sector0 && (cmd_page[6:3] == 4'h0);
    wire [PAGE_W-1:0] sec_first = in_0a ? FIRST_PAGE : in_sector0 ? SECTOR_0B_FIRST
        : {cmd_page[9:7], 7'h00};
    wire [PAGE_W-1:0] sec_last = in_0a ? SECTOR_0A_LAST : in_sector0 ? SECTOR_0B_LAST
        : {cmd_page[9:7], SECTOR_PAGE_LAST};

    // job chosen at select rise; busy engine ignores new frames
    wire idle = (state == ENG_IDLE);
    wire start = cs_rise && idle && (is_block || is_sector || is_chip);
    sfe_job_type job;
    assign job.first_page = is_chip ? FIRST_PAGE : is_sector ? sec_first : blk_first;
    assign job.last_page = is_chip ? LAST_PAGE : is_sector ? sec_last : blk_last;
    assign job.cycles = is_chip ? TIMER_W'(CHIP_CYCLES) : is_sector ? TIMER_W'(SECTOR_CYCLES)
        : TIMER_W'(BLOCK_CYCLES);

    // write protect only takes hold between erases
    always_ff @(posedge ref_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            wp_latched <= 1'b0;
        end else if (clk_en_in && idle && !start) begin
            wp_latched <= ~wp_n_sync;
        end
    end

    // sector guard for the page being swept
    wire protect_on = sw_protect_in | wp_latched;
    wire [SECTOR_IDX_W-1:0] cur_sector = sector_of(cur_page);
    wire cur_guarded = (protect_on & protect_sel_in[cur_sector]) | lockdown_in[cur_sector];
    wire timer_done = (timer >= target - TIMER_W'(1));

    // engine next state: sweep the span, then hold busy until time is up
    always_comb begin
        next_state = state;
        next_cur_page = cur_page;
        next_last_page = last_page;
        next_target = target;
        next_timer = (state == ENG_IDLE) ? '0 : timer + TIMER_W'(1);
        next_erase.we = 1'b0;
        next_erase.page = erase_out.page;
        next_erase.fill = ERASED_BYTE;
        case (state)
            ENG_IDLE: begin
                if (start) begin
                    next_state = ENG_SWEEP;
                    next_cur_page = job.first_page;
                    next_last_page = job.last_page;
                    next_target = job.cycles;
                end
            end
            ENG_SWEEP: begin
                // guarded sectors get no strobe and keep their data
                next_erase.we = ~cur_guarded;
                next_erase.page = cur_page;
                if (cur_page == last_page) begin
                    next_state = ENG_WAIT;
                end else begin
                    next_cur_page = cur_page + PAGE_W'(1);
                end
            end
            ENG_WAIT: begin
                if (timer_done) begin
                    next_state = ENG_IDLE;
                end
            end
            default: begin
                next_state = ENG_IDLE;
            end
        endcase
    end

    // engine registers
    always_ff @(posedge ref_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= ENG_IDLE;
            cur_page <= FIRST_PAGE;
            last_page <= FIRST_PAGE;
            timer <= '0;
            target <= '0;
        end else if (clk_en_in) begin
            state <= next_state;
            cur_page <= next_cur_page;
            last_page <= next_last_page;
            timer <= next_timer;
            target <= next_target;
        end
    end

    // array strobe, registered
    always_ff @(posedge ref_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            erase_out.we <= 1'b0;
            erase_out.page <= FIRST_PAGE;
            erase_out.fill <= ERASED_BYTE;
        end else if (clk_en_in) begin
            erase_out <= next_erase;
        end
    end

    // status outputs from flops
    always_ff @(posedge ref_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            busy_out <= 1'b0;
            protect_active_out <= 1'b0;
        end else if (clk_en_in) begin
            busy_out <= (next_state != ENG_IDLE);
            protect_active_out <= sw_protect_in | wp_latched;
        end
    end
endmodule : sfe_erase_ctrl

// >>> bench/sfe_erase_checker.sv
`timescale 1ns/1ns
// passive watcher of the erase controller ports
module sfe_erase_checker
import sfe_pkg::*;
#(
    parameter int unsigned BLOCK_CYCLES = sfe_pkg::BLOCK_ERASE_CYCLES,
    parameter int unsigned SECTOR_CYCLES = sfe_pkg::SECTOR_ERASE_CYCLES,
    parameter int unsigned CHIP_CYCLES = sfe_pkg::CHIP_ERASE_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    input wire logic binary_page_in,
    input wire logic sw_protect_in,
    input wire logic [sfe_pkg::SECTOR_COUNT-1:0] protect_sel_in,
    input wire logic [sfe_pkg::SECTOR_COUNT-1:0] lockdown_in,
    input wire logic busy_out,
    input wire logic protect_active_out,
    input wire sfe_pkg::sfe_erase_port_type erase_out
);
    logic [31:0] busy_cnt; // cycles spent busy so far
    logic [1:0] up_cnt; // edges since reset release, internal reset lags
    logic run_ok;
    logic [3:0] sec_idx; // sector of the strobed page
    assign run_ok = (up_cnt == 2'h3);
    assign sec_idx = (erase_out.page[9:7] == 3'h0) ? {3'h0, erase_out.page[6:3] != 4'h0}
                                                    : {1'b0, erase_out.page[9:7]} + 4'h1;
    // busy length and settle counters
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_cnt <= 32'h0;
            up_cnt <= 2'h0;
        end else begin
            busy_cnt <= busy_out ? busy_cnt + 32'h1 : 32'h0;
            up_cnt <= run_ok ? up_cnt : up_cnt + 2'h1;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_busy3;
        busy_out [*3];
    endsequence
    property p_fill;
        erase_out.we |-> erase_out.fill == 8'hff;
    endproperty
    property p_we_busy;
        erase_out.we |-> busy_out || $past(busy_out);
    endproperty
    property p_start;
        $rose(busy_out) |-> $past(cs_n_in, 3);
    endproperty
    property p_busy_len;
        $fell(busy_out) |-> busy_cnt >= BLOCK_CYCLES && busy_cnt <= CHIP_CYCLES + 32'h44c;
    endproperty
    property p_step;
        erase_out.we && $past(erase_out.we) |-> erase_out.page == $past(erase_out.page) + 10'h1;
    endproperty
    property p_guard;
        erase_out.we |-> !lockdown_in[sec_idx] && !(protect_active_out && protect_sel_in[sec_idx]);
    endproperty
    property p_sw_prot;
        run_ok && sw_protect_in |=> protect_active_out;
    endproperty
    property p_wp_hold;
        s_busy3 ##0 ($past(sw_protect_in, 2) == sw_protect_in && $past(sw_protect_in) == sw_protect_in)
            |-> $stable(protect_active_out);
    endproperty
    a_fill: assert property (p_fill) else $error("erased page not filled with ones");
    a_we_busy: assert property (p_we_busy) else $error("strobe outside busy");
    a_start: assert property (p_start) else $error("erase began with chip select low");
    a_busy_len: assert property (p_busy_len) else $error("busy length out of range");
    a_step: assert property (p_step) else $error("page sweep not consecutive");
    a_guard: assert property (p_guard) else $error("guarded sector strobed");
    a_sw_prot: assert property (p_sw_prot) else $error("protection not shown");
    a_wp_hold: assert property (p_wp_hold) else $error("protection changed while busy");
    c_we: cover property (erase_out.we);
endmodule : sfe_erase_checker

bind sfe_erase_ctrl sfe_erase_checker #(.BLOCK_CYCLES(BLOCK_CYCLES), .SECTOR_CYCLES(SECTOR_CYCLES),
    .CHIP_CYCLES(CHIP_CYCLES)) i_sfe_erase_checker (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in), .cs_n_in(cs_n_in), .sck_in(sck_in), .si_in(si_in), .wp_n_in(wp_n_in),
    .binary_page_in(binary_page_in), .sw_protect_in(sw_protect_in), .protect_sel_in(protect_sel_in),
    .lockdown_in(lockdown_in), .busy_out(busy_out), .protect_active_out(protect_active_out),
    .erase_out(erase_out));

// >>> bench/sfe_host_model.sv
`timescale 1ns/1ns
// host serial master, mode 0, clock stands low outside frames
module sfe_host_model (
    input wire logic clk_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out
);
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    // page to 24 address bits, don't-care bits sent as zero
    function automatic logic [23:0] addr_of(input logic bin, input logic [9:0] page);
        addr_of = bin ? {6'h00, page, 8'h00} : {5'h00, page, 9'h000};
    endfunction : addr_of
    // n bytes msb first from the top of b, 8 clocks per bit (160 ns)
    task automatic send(input logic [39:0] b, input int n);
        int i;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (i = 0; i < n * 8; i++) begin
            si_out <= b[39-i];
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sck_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        si_out <= ~si_out; // released line shows no stale bit
    endtask : send
endmodule : sfe_host_model

// >>> bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import sfe_pkg::*;
    logic ref_clk_in, rst_n_in, wp_n, bin_mode, sw_prot, cs_n, sck, si, busy, prot_act, saw_busy, prot_seen;
    logic [SECTOR_COUNT-1:0] prot_sel, lock;
    logic [9:0] first_pg, last_pg;
    sfe_erase_port_type erase;
    int err_total, compares, n_we;
    sfe_host_model i_sfe_host_model (.clk_in(ref_clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
    // short erase times keep the run brief
    sfe_erase_ctrl #(.BLOCK_CYCLES(2000), .SECTOR_CYCLES(2000), .CHIP_CYCLES(2000)) i_sfe_erase_ctrl (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .cs_n_in(cs_n), .sck_in(sck),
        .si_in(si), .wp_n_in(wp_n), .binary_page_in(bin_mode), .sw_protect_in(sw_prot),
        .protect_sel_in(prot_sel), .lockdown_in(lock), .busy_out(busy), .protect_active_out(prot_act),
        .erase_out(erase));
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // send one frame, then log strobes until busy drops (bounded)
    task automatic run_cmd(input logic [39:0] b, input int n);
        int k;
        n_we = 0;
        saw_busy = 1'b0;
        prot_seen = 1'b0;
        first_pg = 10'h3ff;
        last_pg = 10'h000;
        i_sfe_host_model.send(b, n);
        for (k = 0; k < 6000; k++) begin
            @(negedge ref_clk_in);
            if (busy === 1'b1) saw_busy = 1'b1;
            if (busy === 1'b1 && prot_act === 1'b1) prot_seen = 1'b1;
            if (erase.we === 1'b1) begin
                n_we++;
                check(erase.fill, ERASED_BYTE);
                if (erase.page < first_pg) first_pg = erase.page;
                if (erase.page > last_pg) last_pg = erase.page;
            end
            if ((saw_busy && busy === 1'b0) || (!saw_busy && k == 40)) break;
        end
        if (k == 6000) begin
            err_total++;
            $display("[ERR] t=%0t busy=%h exp=%h", $time, busy, 1'b0);
            end_sim();
        end
    endtask : run_cmd
    task automatic expect_erase(input logic b, input int cnt, input logic [9:0] f, input logic [9:0] l);
        check(saw_busy, b);
        check(n_we, cnt);
        if (cnt > 0) begin
            check(first_pg, f);
            check(last_pg, l);
        end
    endtask : expect_erase
    // sector 6 in 264 mode, write protect raised mid-erase
    task automatic t_sector();
        fork
            run_cmd({OPC_SECTOR_ERASE, i_sfe_host_model.addr_of(1'b0, 10'h35a), 8'h00}, 4);
            begin
                repeat (300) @(posedge ref_clk_in);
                wp_n <= 1'b0;
            end
        join
        expect_erase(1'b1, 128, 10'h300, 10'h37f);
        check(prot_seen, 1'b0);
        repeat (8) @(negedge ref_clk_in);
        check(prot_act, 1'b1);
        @(posedge ref_clk_in);
        wp_n <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        $display("test sector done");
    endtask : t_sector
    // top block in 256 mode with low page bits set
    task automatic t_block();
        @(posedge ref_clk_in);
        bin_mode <= 1'b1;
        run_cmd({OPC_BLOCK_ERASE, i_sfe_host_model.addr_of(1'b1, 10'h3fd), 8'h00}, 4);
        expect_erase(1'b1, 8, 10'h3f8, 10'h3ff);
        $display("test block done");
    endtask : t_block
    // protected sector 0b untouched, then 0a erased
    task automatic t_prot();
        @(posedge ref_clk_in);
        sw_prot <= 1'b1;
        prot_sel <= 9'h002;
        run_cmd({OPC_SECTOR_ERASE, i_sfe_host_model.addr_of(1'b1, 10'h008), 8'h00}, 4);
        expect_erase(1'b1, 0, 10'h000, 10'h000);
        run_cmd({OPC_SECTOR_ERASE, i_sfe_host_model.addr_of(1'b1, 10'h005), 8'h00}, 4);
        expect_erase(1'b1, 8, 10'h000, 10'h007);
        $display("test protect done");
    endtask : t_prot
    // chip erase with a trailing byte, 0b protected and 7 locked
    task automatic t_chip();
        @(posedge ref_clk_in);
        lock <= 9'h100;
        run_cmd({CHIP_SEQ_0, CHIP_SEQ_1, CHIP_SEQ_2, CHIP_SEQ_3, 8'h55}, 5);
        expect_erase(1'b1, 776, 10'h000, 10'h37f);
        $display("test chip done");
    endtask : t_chip
    // wrong last byte and a cut-short frame start nothing
    task automatic t_refuse();
        run_cmd({CHIP_SEQ_0, CHIP_SEQ_1, CHIP_SEQ_2, 8'h9b, 8'h00}, 4);
        expect_erase(1'b0, 0, 10'h000, 10'h000);
        run_cmd({OPC_SECTOR_ERASE, 8'h06, 8'h00, 8'h00, 8'h00}, 3);
        expect_erase(1'b0, 0, 10'h000, 10'h000);
        $display("test refuse done");
    endtask : t_refuse
    // reset, then the scenarios in turn
    initial begin
        rst_n_in = 1'b0;
        wp_n = 1'b1;
        bin_mode = 1'b0;
        sw_prot = 1'b0;
        prot_sel = 9'h000;
        lock = 9'h000;
        err_total = 0;
        compares = 0;
        repeat (4) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        t_sector();
        t_block();
        t_prot();
        t_chip();
        t_refuse();
        end_sim();
    end
endmodule : testbench
